// File: hw/smad_defs.svh
/*
  Address map, field positions and flash layout constants of the
  system memory address decoder.
  Assumes a 24-bit byte address; included by bare name.
*/
`ifndef SMAD_DEFS_SVH
`define SMAD_DEFS_SVH

// system segment regions
`define SMAD_DUAL_PORT_RAM_LO     24'h00F600
`define SMAD_DUAL_PORT_RAM_HI     24'h00FDFF
`define SMAD_DUAL_PORT_RAM_BIT_LO 24'h00FD00
`define SMAD_SFR_LO       24'h00FE00
`define SMAD_SFR_HI       24'h00FFFF
`define SMAD_SFR_BIT_LO   24'h00FF00
`define SMAD_EXTENDED_FUNCTION_REG_AREA_LO      24'h00F000
`define SMAD_EXTENDED_FUNCTION_REG_AREA_HI      24'h00F1FF
`define SMAD_EXTENDED_FUNCTION_REG_AREA_BIT_LO  24'h00F100
`define SMAD_EXTRA_FUNCTION_REG_AREA_LO      24'h00E000
`define SMAD_EXTRA_FUNCTION_REG_AREA_HI      24'h00EFFF
`define SMAD_DATA_SRAM_LO     24'h008000
`define SMAD_DATA_SRAM_HI     24'h00DFFF
`define SMAD_RSV_DP_LO    24'h00F200
`define SMAD_RSV_DP_HI    24'h00F5FF

// outer segments
`define SMAD_FLASH_BASE   24'hC00000
`define SMAD_FLASH_M0_SZ  24'h010000
`define SMAD_FLASH_END    24'hD90000
`define SMAD_FLASH_RSV_LO 24'hC0F000
`define SMAD_PROGRAM_SRAM_BASE   24'hE00000
`define SMAD_PROGRAM_SRAM_END    24'hE1C000
`define SMAD_EXTIO_LO     24'h200000
`define SMAD_EXTIO_HI     24'h20FFFF

// field positions
`define SMAD_SEG_SHIFT    16
`define SMAD_PAGE_SHIFT   14
`define SMAD_MOD_SHIFT    18
`define SMAD_SECT_SHIFT   12
`define SMAD_BLK_SHIFT    7
`define SMAD_CLUS_SHIFT   2
`define SMAD_ECC_BITS     128

`endif

// File: hw/smad_pkg.sv
/*
  Types shared by the address decoder files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smad_pkg;

  // target codes; the value is also the select bit index
  typedef enum logic [2:0] {
    EXT   = 3'b000,
    DUAL_PORT_RAM = 3'b001,
    DATA_SRAM = 3'b010,
    SPECIAL_FUNCTION_REG_AREA   = 3'b011,
    EXTENDED_FUNCTION_REG_AREA  = 3'b100,
    EXTRA_FUNCTION_REG_AREA  = 3'b101,
    PROGRAM_SRAM = 3'b110,
    FLASH = 3'b111
  } smad_tgt_type;

  // flash read-protection unlock states
  typedef enum logic [1:0] {
    LOCKED = 2'b00,
    HALF   = 2'b01,
    OPEN   = 2'b10
  } smad_lock_type;

endpackage : smad_pkg

// File: hw/smad_region_dec.sv
/*
  Combinational region classifier for one 24-bit address.
  Assumes the caller registers the results.
*/
`timescale 1ns/100ps
`include "smad_defs.svh"

module smad_region_dec (
  input  wire logic [23:0]         addr,       // byte address
  output smad_pkg::smad_tgt_type   tgt,        // selected target
  output logic                     bit_ok,     // direct bit access
  output logic                     flash_rsvd, // internal sector
  output logic                     ext_io,     // external io area
  output logic [2:0]               flash_mod   // flash module index
);

  //////////////////////////////////////////////////////////////////////
  // fixed boundary compare, first match wins so one target only
  always_comb begin
    logic [23:0] off;
    logic [23:0] big;
    off        = 24'(addr - `SMAD_FLASH_BASE);
    big        = 24'(off - `SMAD_FLASH_M0_SZ);
    tgt        = smad_pkg::EXT;
    bit_ok     = 1'b0;
    flash_rsvd = 1'b0;
    ext_io     = 1'b0;
    flash_mod  = 3'h0;
    if (addr[23:16] == 8'h00) begin
      if (addr >= `SMAD_DUAL_PORT_RAM_LO && addr <= `SMAD_DUAL_PORT_RAM_HI) begin
        tgt    = smad_pkg::DUAL_PORT_RAM;
        bit_ok = addr >= `SMAD_DUAL_PORT_RAM_BIT_LO;
      end else if (addr >= `SMAD_SFR_LO) begin
        tgt    = smad_pkg::SPECIAL_FUNCTION_REG_AREA;
        bit_ok = addr >= `SMAD_SFR_BIT_LO;
      end else if (addr >= `SMAD_EXTENDED_FUNCTION_REG_AREA_LO &&
                   addr <= `SMAD_EXTENDED_FUNCTION_REG_AREA_HI) begin
        tgt    = smad_pkg::EXTENDED_FUNCTION_REG_AREA;
        bit_ok = addr >= `SMAD_EXTENDED_FUNCTION_REG_AREA_BIT_LO;
      end else if (addr >= `SMAD_EXTRA_FUNCTION_REG_AREA_LO &&
                   addr <= `SMAD_EXTRA_FUNCTION_REG_AREA_HI) begin
        tgt = smad_pkg::EXTRA_FUNCTION_REG_AREA;
      end else if (addr >= `SMAD_DATA_SRAM_LO &&
                   addr <= `SMAD_DATA_SRAM_HI) begin
        tgt = smad_pkg::DATA_SRAM;
      end
    end else if (addr >= `SMAD_FLASH_BASE &&
                 addr < `SMAD_FLASH_END) begin
      tgt = smad_pkg::FLASH;
      if (off < `SMAD_FLASH_M0_SZ)
        flash_mod = 3'h0;
      else
        flash_mod = 3'(big[20:`SMAD_MOD_SHIFT]) + 3'h1;
      flash_rsvd = addr >= `SMAD_FLASH_RSV_LO &&
                   off < `SMAD_FLASH_M0_SZ;
    end else if (addr >= `SMAD_PROGRAM_SRAM_BASE &&
                 addr < `SMAD_PROGRAM_SRAM_END) begin
      tgt = smad_pkg::PROGRAM_SRAM;
    end else begin
      ext_io = addr >= `SMAD_EXTIO_LO && addr <= `SMAD_EXTIO_HI;
    end
  end

endmodule : smad_region_dec

// File: hw/smad_top.sv
/*
  System memory address decoder: steers code fetches and data
  transfers to their targets, maps general registers into the
  dual port ram, guards flash and program sram, corrects flash reads.
  Assumes requesters, flash and sram share mclk and a synchronous
  reset; requests are single-cycle strobes, answered one edge later.
*/
// Functional notes
// - 256 segments of 64K, four 16K pages
// - byte or word access at any address
// - dual port ram, data sram, register areas decoded only in segment zero
// - F600 to FDFF is dual port ram
// - 8000 to DFFF is data sram
// - reserved segment zero areas become external bus cycles
// - top 256 bytes and registers bit addressable
// - register bank maps sixteen words or bytes
// - two 512 byte special register areas
// - fetches via program unit, data via data unit
// - both units transfer concurrently
// - protected program sram rejects writes
// - external io area disables pipeline shortcuts
// - seven flash modules in 4K sectors
// - top sector of first segment reserved
// - sector erase, 128 byte blocks, clusters
// - 128 bit reads pass error correction
// - read protection unlocked by password sequence
`timescale 1ns/100ps
`include "smad_defs.svh"

module smad_top (
  input  wire logic         mclk,          // system clock
  input  wire logic         rst,           // sync reset, high
  // program unit side
  input  wire logic         fch_req,       // fetch strobe
  input  wire logic [23:0]  fch_addr,      // fetch address
  input  wire logic         fch_word,      // 1 word, 0 byte
  output logic              fch_ack,       // answer pulse
  output logic [7:0]        fch_sel,       // one-hot target
  output logic              fch_err,       // fetch refused
  output logic [1:0]        fch_be,        // byte lanes
  output logic [7:0]        fch_seg,       // segment number
  output logic [9:0]        fch_page,      // data page number
  output logic [2:0]        fch_fmod,      // flash module
  output logic              fch_noopt,     // shortcuts off
  // data unit side
  input  wire logic         dat_req,       // data strobe
  input  wire logic [23:0]  dat_addr,      // data address
  input  wire logic         dat_word,      // 1 word, 0 byte
  input  wire logic         dat_write,     // 1 write
  output logic              dat_ack,       // answer pulse
  output logic [7:0]        dat_sel,       // one-hot target
  output logic              dat_err,       // access refused
  output logic [1:0]        dat_be,        // byte lanes
  output logic [7:0]        dat_seg,       // segment number
  output logic [9:0]        dat_page,      // data page number
  output logic              dat_bit_ok,    // direct bit access
  output logic [2:0]        dat_fmod,      // flash module
  output logic [8:0]        dat_sector,    // flash sector
  output logic [6:0]        dat_cluster,   // protection cluster
  output logic [4:0]        dat_block,     // 128 byte block
  output logic              dat_noopt,     // shortcuts off
  // general register mapping
  input  wire logic         gpr_req,       // register strobe
  input  wire logic [23:0]  gpr_cp,        // bank base
  input  wire logic [3:0]   gpr_num,       // register number
  input  wire logic         gpr_word,      // 1 word register
  output logic              gpr_ack,       // answer pulse
  output logic [23:0]       gpr_addr,      // mapped address
  output logic              gpr_bit_ok,    // bit access allowed
  output logic              gpr_err,       // outside dual_port_ram
  // protection
  input  wire logic [16:0]  program_sram_wp_size, // protected bytes
  input  wire logic         rp_enable,     // flash read protect
  input  wire logic         pw_valid,      // password word
  input  wire logic [15:0]  pw_word,       // password data
  input  wire logic [31:0]  pw_key,        // stored password
  input  wire logic         relock,        // end unlock
  output logic              flash_unlocked, // unlock active
  // flash read return
  input  wire logic         frd_valid,     // flash data valid
  input  wire logic [127:0] frd_data,      // raw flash line
  input  wire logic [7:0]   frd_chk,       // stored check bits
  output logic              rd_valid,      // corrected valid
  output logic [127:0]      rd_data,       // corrected line
  output logic              rd_fixed       // a bit was flipped
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] smad_onehot(
    input smad_pkg::smad_tgt_type t);
    return 8'(8'h01 << t);
  endfunction : smad_onehot

  function automatic logic [1:0] smad_lanes(
    input logic word, input logic a0);
    return word ? 2'b11 : (a0 ? 2'b10 : 2'b01);
  endfunction : smad_lanes

  // position-xor check code, names the flipped bit directly
  function automatic logic [7:0] smad_ecc(input logic [127:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < `SMAD_ECC_BITS; i++) begin
      if (d[i])
        s = s ^ 8'(i + 1);
    end
    return s;
  endfunction : smad_ecc

  //////////////////////////////////////////////////////////////////////
  // region decode, one per unit so both run in the same cycle

  smad_pkg::smad_tgt_type f_tgt;
  smad_pkg::smad_tgt_type d_tgt;
  logic                   f_rsvd;
  logic                   f_io;
  logic [2:0]             f_mod;
  logic                   d_bit;
  logic                   d_rsvd;
  logic                   d_io;
  logic [2:0]             d_mod;
  logic                   rp_block;
  logic [23:0]            d_off;
  logic [23:0]            p_off;

  smad_region_dec u_fch_dec (
    .addr       (fch_addr),
    .tgt        (f_tgt),
    .bit_ok     (),
    .flash_rsvd (f_rsvd),
    .ext_io     (f_io),
    .flash_mod  (f_mod)
  );

  smad_region_dec u_dat_dec (
    .addr       (dat_addr),
    .tgt        (d_tgt),
    .bit_ok     (d_bit),
    .flash_rsvd (d_rsvd),
    .ext_io     (d_io),
    .flash_mod  (d_mod)
  );

  // locked flash refuses reads until the password opens it
  assign rp_block = rp_enable && !flash_unlocked;
  assign d_off    = 24'(dat_addr - `SMAD_FLASH_BASE);
  assign p_off    = 24'(dat_addr - `SMAD_PROGRAM_SRAM_BASE);

  //////////////////////////////////////////////////////////////////////
  // fetch channel
  always_ff @(posedge mclk) begin
    if (rst) begin
      fch_ack   <= 1'b0;
      fch_sel   <= 8'h00;
      fch_err   <= 1'b0;
      fch_be    <= 2'b00;
      fch_seg   <= 8'h00;
      fch_page  <= 10'h000;
      fch_fmod  <= 3'h0;
      fch_noopt <= 1'b0;
    end else begin
      fch_ack <= fch_req;
      if (fch_req) begin
        fch_sel   <= smad_onehot(f_tgt);
        fch_err   <= f_rsvd || (f_tgt == smad_pkg::FLASH && rp_block);
        fch_be    <= smad_lanes(fch_word, fch_addr[0]);
        fch_seg   <= fch_addr[23:`SMAD_SEG_SHIFT];
        fch_page  <= fch_addr[23:`SMAD_PAGE_SHIFT];
        fch_fmod  <= f_mod;
        fch_noopt <= f_io;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // data channel
  always_ff @(posedge mclk) begin
    if (rst) begin
      dat_ack     <= 1'b0;
      dat_sel     <= 8'h00;
      dat_err     <= 1'b0;
      dat_be      <= 2'b00;
      dat_seg     <= 8'h00;
      dat_page    <= 10'h000;
      dat_bit_ok  <= 1'b0;
      dat_fmod    <= 3'h0;
      dat_sector  <= 9'h000;
      dat_cluster <= 7'h00;
      dat_block   <= 5'h00;
      dat_noopt   <= 1'b0;
    end else begin
      dat_ack <= dat_req;
      if (dat_req) begin
        dat_sel     <= smad_onehot(d_tgt);
        dat_err     <= (d_tgt == smad_pkg::PROGRAM_SRAM && dat_write &&
                        p_off < {7'h00, program_sram_wp_size}) ||
                       d_rsvd ||
                       (d_tgt == smad_pkg::FLASH && rp_block);
        dat_be      <= smad_lanes(dat_word, dat_addr[0]);
        dat_seg     <= dat_addr[23:`SMAD_SEG_SHIFT];
        dat_page    <= dat_addr[23:`SMAD_PAGE_SHIFT];
        dat_bit_ok  <= d_bit;
        dat_fmod    <= d_mod;
        dat_sector  <= d_off[20:`SMAD_SECT_SHIFT];
        dat_cluster <= d_off[20:`SMAD_SECT_SHIFT + `SMAD_CLUS_SHIFT];
        dat_block   <= d_off[`SMAD_SECT_SHIFT - 1:`SMAD_BLK_SHIFT];
        dat_noopt   <= d_io;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // general register mapping; bytes only cover the first eight words
  logic [23:0] g_addr;
  assign g_addr = gpr_word ? 24'(gpr_cp + {19'h0, gpr_num, 1'b0})
                           : 24'(gpr_cp + {20'h0, gpr_num});

  always_ff @(posedge mclk) begin
    if (rst) begin
      gpr_ack    <= 1'b0;
      gpr_addr   <= 24'h000000;
      gpr_bit_ok <= 1'b0;
      gpr_err    <= 1'b0;
    end else begin
      gpr_ack <= gpr_req;
      if (gpr_req) begin
        gpr_addr   <= g_addr;
        gpr_err    <= g_addr < `SMAD_DUAL_PORT_RAM_LO ||
                      g_addr > `SMAD_DUAL_PORT_RAM_HI;
        gpr_bit_ok <= g_addr >= `SMAD_DUAL_PORT_RAM_LO &&
                      g_addr <= `SMAD_DUAL_PORT_RAM_HI;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // password unlock; a wrong word restarts, relock always wins
  smad_pkg::smad_lock_type lock_reg;
  smad_pkg::smad_lock_type lock_next;

  always_comb begin
    lock_next = lock_reg;
    unique case (lock_reg)
      smad_pkg::LOCKED: begin
        if (pw_valid && pw_word == pw_key[15:0])
          lock_next = smad_pkg::HALF;
      end
      smad_pkg::HALF: begin
        if (pw_valid)
          lock_next = (pw_word == pw_key[31:16]) ? smad_pkg::OPEN
                                                 : smad_pkg::LOCKED;
      end
      smad_pkg::OPEN: begin
        lock_next = smad_pkg::OPEN;
      end
      default: begin
        lock_next = smad_pkg::LOCKED;
      end
    endcase
    if (relock)
      lock_next = smad_pkg::LOCKED;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_reg       <= smad_pkg::LOCKED;
      flash_unlocked <= 1'b0;
    end else begin
      lock_reg       <= lock_next;
      flash_unlocked <= lock_next == smad_pkg::OPEN;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flash read correction; a check-bit error is not separable here
  logic [7:0]   syn;
  logic [127:0] fixed;
  logic         flip;

  always_comb begin
    syn   = smad_ecc(frd_data) ^ frd_chk;
    flip  = syn != 8'h00 && syn <= 8'h80;
    fixed = frd_data;
    if (flip)
      fixed[7'(syn - 8'h01)] = ~frd_data[7'(syn - 8'h01)];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 128'h0;
      rd_fixed <= 1'b0;
    end else begin
      rd_valid <= frd_valid;
      if (frd_valid) begin
        rd_data  <= fixed;
        rd_fixed <= flip;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_pw_first;
    pw_valid && !relock && lock_reg == smad_pkg::LOCKED &&
    pw_word == pw_key[15:0];
  endsequence

  sequence s_pw_second;
    pw_valid && !relock && pw_word == pw_key[31:16];
  endsequence

  // each channel is judged on its own answer, the other may be idle
  a_sel_one_hot:
    assert property (dat_ack |-> $onehot(dat_sel))
    else $error("data select not one-hot");

  a_fch_one_hot:
    assert property (fch_ack |-> $onehot(fch_sel))
    else $error("fetch select not one-hot");

  a_dual_port_ram_range:
    assert property (dat_req && dat_addr >= `SMAD_DUAL_PORT_RAM_LO &&
                     dat_addr <= `SMAD_DUAL_PORT_RAM_HI
                     |=> dat_sel == 8'h02)
    else $error("dual port ram not selected");

  a_data_sram_range:
    assert property (dat_req && dat_addr >= `SMAD_DATA_SRAM_LO &&
                     dat_addr <= `SMAD_DATA_SRAM_HI
                     |=> dat_sel == 8'h04)
    else $error("data sram not selected");

  a_reserved_ext:
    assert property (dat_req && dat_addr >= `SMAD_RSV_DP_LO &&
                     dat_addr <= `SMAD_RSV_DP_HI
                     |=> dat_sel == 8'h01)
    else $error("reserved area not external");

  a_system_seg:
    assert property (dat_ack && dat_seg != 8'h00
                     |-> dat_sel[5:1] == 5'h00)
    else $error("internal target outside segment zero");

  a_page_split:
    assert property (dat_req |=> dat_page == $past(dat_addr[23:14]) &&
                     dat_seg == $past(dat_addr[23:16]))
    else $error("segment or page wrong");

  a_both_units:
    assert property (fch_req && dat_req |=> fch_ack && dat_ack)
    else $error("concurrent requests not both answered");

  a_wp_reject:
    assert property (dat_req && dat_write &&
                     dat_addr >= `SMAD_PROGRAM_SRAM_BASE &&
                     p_off < {7'h00, program_sram_wp_size} |=> dat_err)
    else $error("protected program_sram write accepted");

  a_rsvd_sector:
    assert property (fch_req && fch_addr >= `SMAD_FLASH_RSV_LO &&
                     fch_addr < 24'hC10000 |=> fch_err)
    else $error("reserved flash sector fetched");

  a_pw_unlock:
    assert property (s_pw_first ##1 s_pw_second |=> flash_unlocked
                     ##1 (flash_unlocked || $past(relock)))
    else $error("password sequence did not unlock");

  a_gpr_word:
    assert property (gpr_req && gpr_word |=> gpr_addr ==
                     24'($past(gpr_cp) + {19'h0, $past(gpr_num), 1'b0}))
    else $error("register address wrong");

  a_lane_byte:
    assert property (dat_req && !dat_word |=> $onehot(dat_be) &&
                     dat_be[1] == $past(dat_addr[0]))
    else $error("byte lane wrong");

  a_ecc_clean:
    assert property (frd_valid && smad_ecc(frd_data) == frd_chk
                     |=> !rd_fixed && rd_data == $past(frd_data))
    else $error("clean flash line altered");

endmodule : smad_top

// File: test/smad_cpu_model.sv
/*
  Requester model for the decoder: random fetch, data and register
  strobes, one new set of values every cycle.
  Assumes the bench supplies mclk and a run level.
*/
`timescale 1ns/100ps
module smad_cpu_model (
  input  wire logic  mclk,      // system clock
  input  wire logic  run,       // issue requests
  output logic       fch_req,   // fetch strobe
  output logic [23:0] fch_addr, // fetch address
  output logic       fch_word,  // word fetch
  output logic       dat_req,   // data strobe
  output logic [23:0] dat_addr, // data address
  output logic       dat_word,  // word data
  output logic       dat_write, // data write
  output logic       gpr_req,   // register strobe
  output logic [23:0] gpr_cp,   // bank base
  output logic [3:0] gpr_num,   // register number
  output logic       gpr_word   // word register
);
  // segments that between them reach every target kind
  localparam logic [7:0] SEGS [8] = '{8'h00, 8'h00, 8'hC0, 8'hC1,
                                      8'hD8, 8'hE1, 8'h20, 8'h55};
  ////////////////////////////////////////////////////////////////////
  // fresh values every cycle, so an idle line never holds stale data
  initial forever begin
    // fetch and data issued on their own channels
    fch_req = run & 1'($urandom);
    fch_addr = {SEGS[$urandom % 8], 16'($urandom)};
    // access size set by the requester
    fch_word = 1'($urandom);
    dat_req = run & 1'($urandom);
    dat_addr = {SEGS[$urandom % 8], 16'($urandom)};
    dat_word = 1'($urandom);
    // no write data is carried, so unused slots never see ones
    dat_write = 1'($urandom);
    gpr_req = run & 1'($urandom);
    gpr_cp = (24'h00F500 + 24'($urandom % 32'hA00)) & 24'hFFFFFE;
    gpr_num = 4'($urandom);
    gpr_word = 1'($urandom);
    @(posedge mclk);
    #1;
  end
endmodule : smad_cpu_model

// File: test/tb_system_memory_address_decoder.sv
/*
  Self-checking bench: random traffic from the requester model,
  flash lines with single flipped bits, password unlock and relock.
  Assumes the design answers every strobe one edge later.
*/
`timescale 1ns/100ps
module tb_system_memory_address_decoder;
  logic mclk = 0, rst = 1, run = 0;
  logic fch_req, fch_word, dat_req, dat_word, dat_write, gpr_req, gpr_word;
  logic [23:0] fch_addr, dat_addr, gpr_cp, gpr_addr;
  logic [3:0] gpr_num;
  logic [16:0] program_sram_wp_size = 0;
  logic rp_enable = 0, pw_valid = 0, relock = 0, frd_valid = 0;
  logic [15:0] pw_word = 0;
  logic [31:0] pw_key = 0;
  logic [127:0] frd_data = 0, rd_data, r_d;
  logic [7:0] frd_chk = 0, fch_sel, fch_seg, dat_sel, dat_seg;
  logic fch_ack, fch_err, fch_noopt, dat_ack, dat_err, dat_bit_ok;
  logic dat_noopt, gpr_ack, gpr_bit_ok, gpr_err, flash_unlocked;
  logic rd_valid, rd_fixed;
  logic [1:0] fch_be, dat_be;
  logic [9:0] fch_page, dat_page;
  logic [2:0] fch_fmod, dat_fmod;
  logic [8:0] dat_sector;
  logic [6:0] dat_cluster;
  logic [4:0] dat_block;
  logic [23:0] f_a, d_a, g_a, off;
  logic f_v = 0, d_v = 0, g_v = 0, r_v = 0, f_w, d_w, d_wr, lk, skip = 0;
  int n_fail = 0, checks = 0, cyc = 0, st = 0, syn, wp, i;

  smad_top u_dut (.mclk, .rst, .fch_req, .fch_addr, .fch_word, .fch_ack,
    .fch_sel, .fch_err, .fch_be, .fch_seg, .fch_page, .fch_fmod,
    .fch_noopt, .dat_req, .dat_addr, .dat_word, .dat_write, .dat_ack,
    .dat_sel, .dat_err, .dat_be, .dat_seg, .dat_page, .dat_bit_ok,
    .dat_fmod, .dat_sector, .dat_cluster, .dat_block, .dat_noopt,
    .gpr_req, .gpr_cp, .gpr_num, .gpr_word, .gpr_ack, .gpr_addr,
    .gpr_bit_ok, .gpr_err, .program_sram_wp_size, .rp_enable, .pw_valid,
    .pw_word, .pw_key, .relock, .flash_unlocked, .frd_valid, .frd_data,
    .frd_chk, .rd_valid, .rd_data, .rd_fixed);
  smad_cpu_model u_cpu (.mclk, .run, .fch_req, .fch_addr, .fch_word,
    .dat_req, .dat_addr, .dat_word, .dat_write, .gpr_req, .gpr_cp,
    .gpr_num, .gpr_word);

  always #2 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////
  // reference model of the address map
  function automatic int tgt(input logic [23:0] a);
    if (a >= 24'hC00000 && a < 24'hD90000) return 7;
    if (a >= 24'hE00000 && a < 24'hE1C000) return 6;
    if (a[23:16] != 8'h00) return 0;
    if (a >= 24'h00FE00) return 3;
    if (a >= 24'h00F600) return 1;
    if (a >= 24'h00F200) return 0;
    if (a >= 24'h00F000) return 4;
    if (a >= 24'h00E000) return 5;
    if (a >= 24'h008000) return 2;
    return 0;
  endfunction : tgt
  function automatic logic ferr(input logic [23:0] a);
    return tgt(a) == 7 && ((a >= 24'hC0F000 && a < 24'hC10000) || lk);
  endfunction : ferr
  function automatic logic [7:0] ecc(input logic [127:0] d);
    ecc = 8'h00;
    for (int k = 0; k < 128; k++) if (d[k]) ecc ^= 8'(k + 1);
  endfunction : ecc
  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test;
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic pw_send(logic [15:0] w);
    @(posedge mclk);
    #1 pw_valid = 1;
    pw_word = w;
    @(posedge mclk);
    #1 pw_valid = 0;
  endtask : pw_send
  ////////////////////////////////////////////////////////////////////
  // capture each request at the edge that takes it
  always @(posedge mclk) begin
    lk = rp_enable && st != 2;
    {f_v, f_a, f_w} = {fch_req && !rst, fch_addr, fch_word};
    {d_v, d_a, d_w, d_wr} = {dat_req && !rst, dat_addr, dat_word, dat_write};
    g_v = gpr_req && !rst;
    g_a = gpr_word ? gpr_cp + {gpr_num, 1'b0} : gpr_cp + 24'(gpr_num);
    r_v = frd_valid && !rst;
    syn = int'(ecc(frd_data) ^ frd_chk);
    r_d = frd_data;
    if (syn != 0 && syn <= 128) r_d[syn - 1] = !r_d[syn - 1];
    wp = program_sram_wp_size;
    skip = relock;
    if (rst || relock) st = 0;
    else if (pw_valid && st == 0) st = pw_word == pw_key[15:0] ? 1 : 0;
    else if (pw_valid && st == 1) st = pw_word == pw_key[31:16] ? 2 : 0;
  end
  // outputs are settled by the falling edge after the taking edge
  always @(negedge mclk) begin
    off = d_a - 24'hC00000;
    chk("fch_ack", f_v, fch_ack);
    chk("dat_ack", d_v, dat_ack);
    chk("gpr_ack", g_v, gpr_ack);
    chk("rd_valid", r_v, rd_valid);
    if (!skip) chk("unlocked", st == 2, flash_unlocked);
    if (f_v) begin
      chk("fch_sel", 8'h01 << tgt(f_a), fch_sel);
      chk("fch_be", f_w ? 2'b11 : {f_a[0], !f_a[0]}, fch_be);
      chk("fch_err", ferr(f_a), fch_err);
      chk("fch_noopt", f_a[23:16] == 8'h20, fch_noopt);
      chk("fch_seg", f_a[23:16], fch_seg);
      chk("fch_page", f_a[23:14], fch_page);
    end
    if (f_v && tgt(f_a) == 7)
      chk("fch_fmod", f_a < 24'hC10000 ? 0
          : 1 + ((f_a - 24'hC10000) >> 18), fch_fmod);
    if (d_v) begin
      chk("dat_sel", 8'h01 << tgt(d_a), dat_sel);
      chk("dat_be", d_w ? 2'b11 : {d_a[0], !d_a[0]}, dat_be);
      chk("dat_seg", d_a[23:16], dat_seg);
      chk("dat_noopt", d_a[23:16] == 8'h20, dat_noopt);
      chk("dat_page", d_a[23:14], dat_page);
      chk("dat_err", ferr(d_a) || (tgt(d_a) == 6 && d_wr
          && d_a - 24'hE00000 < wp), dat_err);
      chk("dat_bit_ok", d_a[23:16] == 8'h00 && (d_a[15:8] == 8'hFD
          || d_a[15:8] == 8'hFF || d_a[15:8] == 8'hF1), dat_bit_ok);
    end
    if (d_v && tgt(d_a) == 7) begin
      chk("dat_fmod", off < 24'h010000 ? 0
          : 1 + ((off - 24'h010000) >> 18), dat_fmod);
      chk("dat_sector", off[20:12], dat_sector);
      chk("dat_cluster", off[20:14], dat_cluster);
      chk("dat_block", off[11:7], dat_block);
    end
    if (g_v) begin
      chk("gpr_addr", g_a, gpr_addr);
      chk("gpr_bit_ok", g_a >= 24'h00F600 && g_a <= 24'h00FDFF,
          gpr_bit_ok);
      chk("gpr_err", g_a < 24'h00F600 || g_a > 24'h00FDFF, gpr_err);
    end
    if (r_v) begin
      chk("rd_data", r_d, rd_data);
      chk("rd_fixed", syn != 0 && syn <= 128, rd_fixed);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // flash lines with at most one flipped data bit
  always @(posedge mclk) begin
    #1 frd_valid = run & 1'($urandom);
    frd_data = {$urandom, $urandom, $urandom, $urandom};
    frd_chk = ecc(frd_data);
    i = $urandom % 200;
    if (i < 128) frd_data[i] = !frd_data[i];
  end
  // bound on run length: tests need about 2730 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(35));
    pw_key = $urandom;
    program_sram_wp_size = 17'($urandom % 32'h1C000);
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    run = 1;
    repeat (2000) @(posedge mclk);
    #1 rp_enable = 1;
    repeat (200) @(posedge mclk);
    pw_send(pw_key[15:0]);
    pw_send(~pw_key[31:16]);
    pw_send(pw_key[15:0]);
    pw_send(pw_key[31:16]);
    repeat (200) @(posedge mclk);
    #1 run = 0;
    repeat (2) @(posedge mclk);
    #1 relock = 1;
    @(posedge mclk);
    #1 relock = 0;
    repeat (2) @(posedge mclk);
    #1 run = 1;
    repeat (200) @(posedge mclk);
    #1 rst = 1;
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    repeat (100) @(posedge mclk);
    finish_test;
  end
endmodule : tb_system_memory_address_decoder
